// ==== accel_control_selftest_regs.sv ====
// Control register, self-test sequencing and axis output registers
`timescale 1ns/100ps
module accel_control_selftest_regs
#(
   parameter int unsigned MEM_CYCLES  = accel_regs_pkg::MEM_CHECK_CYCLES,
   parameter int unsigned GRAV_CYCLES = accel_regs_pkg::GRAV_CHECK_CYCLES,
   parameter logic [7:0]  IDENT_VALUE = accel_regs_pkg::IDENT_DEFAULT
)
(
   // Clock and reset
   input  wire logic                                 CLK_IN,
   input  wire logic                                 RESETN_IN,
   // Decoded register access
   input  wire logic [7:0]                           REG_ADDR_IN,
   input  wire logic                                 REG_WRITE_IN,
   input  wire logic [7:0]                           REG_WDATA_IN,
   input  wire logic                                 REG_READ_IN,
   output logic      [7:0]                           REG_RDATA_OUT,
   // Frame status bits
   output logic                                      FRAME_RST_FLAG_OUT,
   output logic                                      FRAME_DIAG_OUT,
   output logic                                      ACCESS_BLOCKED_OUT,
   // Sensing path
   input  wire logic [accel_regs_pkg::AXIS_BITS-1:0] AXIS_X_IN,
   input  wire logic [accel_regs_pkg::AXIS_BITS-1:0] AXIS_Y_IN,
   input  wire logic [accel_regs_pkg::AXIS_BITS-1:0] AXIS_Z_IN,
   output logic                                      POWER_DOWN_OUT,
   // Self-test hooks
   input  wire logic                                 MEM_CHECK_OK_IN,
   input  wire logic                                 CONT_CHECK_FAIL_IN,
   input  wire logic                                 GRAV_CHECK_FAIL_IN,
   output logic                                      CONT_CHECK_ENABLE_OUT,
   output logic                                      GRAV_CHECK_BUSY_OUT
);
   import accel_regs_pkg::*;

   logic [7:0]           ctrl_reg;
   logic [7:0]           ctrl_next;
   logic                 startup_reg;
   logic                 mem_busy;
   logic                 mem_done;
   logic                 mem_start;
   logic                 grav_busy;
   logic                 grav_done;
   logic                 grav_start;
   logic                 wr_ok;
   logic                 rd_ok;
   logic                 check_lock;
   logic                 checksum_fault_reg;
   logic                 continuous_check_result_reg;
   logic                 gravity_check_result_reg;
   logic                 diag_reg;
   logic [7:0]           rdata_reg;
   logic [7:0]           rdata_next;
   logic [AXIS_BITS-1:0] axis_in   [AXIS_COUNT];
   logic [15:0]          axis_word [AXIS_COUNT];
   logic [7:0]           axis_low  [AXIS_COUNT];

   assign axis_in[0] = AXIS_X_IN;
   assign axis_in[1] = AXIS_Y_IN;
   assign axis_in[2] = AXIS_Z_IN;

   // ************************************************************
   // Access qualification
   // ************************************************************
   // Accesses during the memory check are dropped, not queued
   assign wr_ok = REG_WRITE_IN && (REG_ADDR_IN == CTRL_ADDR) && !mem_busy;
   assign rd_ok = REG_READ_IN && !mem_busy;

   // ************************************************************
   // Control register
   // ************************************************************
   assign check_lock = ctrl_reg[PDOWN_BIT] | ctrl_reg[MEM_BIT]
                     | REG_WDATA_IN[PDOWN_BIT] | REG_WDATA_IN[MEM_BIT];

   always_comb
   begin
      ctrl_next = ctrl_reg;
      if (mem_done)
         ctrl_next[MEM_BIT] = 1'b0;
      if (grav_done)
         ctrl_next[GRAV_BIT] = 1'b0;
      if (wr_ok)
      begin
         ctrl_next = REG_WDATA_IN & ~CTRL_RSVD;
         ctrl_next[RST_FLAG_BIT] = ctrl_reg[RST_FLAG_BIT]
                                 & REG_WDATA_IN[RST_FLAG_BIT];
         ctrl_next[CONT_BIT] = REG_WDATA_IN[CONT_BIT] & ~check_lock;
         ctrl_next[GRAV_BIT] = REG_WDATA_IN[GRAV_BIT] & ~check_lock;
         ctrl_next[MEM_BIT] = REG_WDATA_IN[MEM_BIT]
                            & ~(ctrl_reg[PDOWN_BIT]
                            | REG_WDATA_IN[PDOWN_BIT]);
      end
   end
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
         ctrl_reg <= CTRL_RESET;
      else
         ctrl_reg <= ctrl_next;
   end

   // ************************************************************
   // Self-test sequencing
   // ************************************************************
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
         startup_reg <= 1'b1;
      else
         startup_reg <= 1'b0;
   end

   // Startup run leaves the start bit at zero
   assign mem_start = startup_reg
                    | (ctrl_next[MEM_BIT] & ~ctrl_reg[MEM_BIT]);
   assign grav_start = ctrl_next[GRAV_BIT] & ~ctrl_reg[GRAV_BIT];

   check_timer #(.LENGTH(MEM_CYCLES)) u_mem_timer
   (
      .clk_in    (CLK_IN),
      .resetn_in (RESETN_IN),
      .start_in  (mem_start),
      .busy_out  (mem_busy),
      .done_out  (mem_done)
   );

   // Independent of the continuous check, so both run together
   check_timer #(.LENGTH(GRAV_CYCLES)) u_grav_timer
   (
      .clk_in    (CLK_IN),
      .resetn_in (RESETN_IN),
      .start_in  (grav_start),
      .busy_out  (grav_busy),
      .done_out  (grav_done)
   );

   // ************************************************************
   // Result flags
   // ************************************************************
   // A new memory check clears the old fault; a failure wins
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
         checksum_fault_reg <= 1'b0;
      else if (mem_done && !MEM_CHECK_OK_IN)
         checksum_fault_reg <= 1'b1;
      else if (mem_start)
         checksum_fault_reg <= 1'b0;
   end

   // Sticky until the status read; a new failure beats the clear
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
         continuous_check_result_reg <= 1'b0;
      else if (ctrl_reg[CONT_BIT] && CONT_CHECK_FAIL_IN)
         continuous_check_result_reg <= 1'b1;
      else if (rd_ok && REG_ADDR_IN == INT_STATUS_ADDR)
         continuous_check_result_reg <= 1'b0;
   end
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
         gravity_check_result_reg <= 1'b0;
      else if (grav_done && GRAV_CHECK_FAIL_IN)
         gravity_check_result_reg <= 1'b1;
      else if (rd_ok && REG_ADDR_IN == INT_STATUS_ADDR)
         gravity_check_result_reg <= 1'b0;
   end
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
         diag_reg <= 1'b0;
      else
         diag_reg <= checksum_fault_reg | continuous_check_result_reg
                   | gravity_check_result_reg;
   end

   // ************************************************************
   // Axis output registers
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < AXIS_COUNT; gi++)
      begin : g_axis
         always_ff @(posedge CLK_IN or negedge RESETN_IN)
         begin
            if (!RESETN_IN)
               axis_word[gi] <= WORD_ZERO;
            else if (ctrl_reg[PDOWN_BIT])
               axis_word[gi] <= WORD_ZERO;
            else if (checksum_fault_reg)
               axis_word[gi] <= WORD_MEM_FAIL;
            else if (continuous_check_result_reg | gravity_check_result_reg)
               axis_word[gi] <= WORD_PATH_FAIL;
            else
               axis_word[gi] <= {axis_in[gi], AXIS_PAD};
         end
         // Low byte is frozen by the high-byte read for a coherent pair
         always_ff @(posedge CLK_IN or negedge RESETN_IN)
         begin
            if (!RESETN_IN)
               axis_low[gi] <= BYTE_ZERO;
            else if (rd_ok && REG_ADDR_IN == AXIS_HIGH_BASE
                     + 8'(gi) * AXIS_STRIDE)
               axis_low[gi] <= axis_word[gi][7:0];
         end
      end
   endgenerate

   // ************************************************************
   // Read data
   // ************************************************************
   always_comb
   begin
      rdata_next = rdata_reg;
      if (rd_ok)
      begin
         rdata_next = BYTE_ZERO;
         case (REG_ADDR_IN)
            CTRL_ADDR:
               rdata_next = ctrl_reg;
            STATUS_ADDR:
               rdata_next[CSUM_BIT] = checksum_fault_reg;
            INT_STATUS_ADDR:
            begin
               rdata_next[INT_CONT_BIT] = continuous_check_result_reg;
               rdata_next[INT_GRAV_BIT] = gravity_check_result_reg;
            end
            IDENT_ADDR:
               rdata_next = IDENT_VALUE;
            default:
               rdata_next = BYTE_ZERO;
         endcase
         for (int i = 0; i < AXIS_COUNT; i++)
         begin
            if (REG_ADDR_IN == AXIS_LOW_BASE + 8'(i) * AXIS_STRIDE)
               rdata_next = axis_low[i];
            if (REG_ADDR_IN == AXIS_HIGH_BASE + 8'(i) * AXIS_STRIDE)
               rdata_next = axis_word[i][15:8];
         end
      end
   end

   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
         rdata_reg <= BYTE_ZERO;
      else
         rdata_reg <= rdata_next;
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign REG_RDATA_OUT         = rdata_reg;
   assign FRAME_RST_FLAG_OUT    = ctrl_reg[RST_FLAG_BIT];
   assign FRAME_DIAG_OUT        = diag_reg;
   assign ACCESS_BLOCKED_OUT    = mem_busy;
   assign POWER_DOWN_OUT        = ctrl_reg[PDOWN_BIT];
   assign CONT_CHECK_ENABLE_OUT = ctrl_reg[CONT_BIT];
   assign GRAV_CHECK_BUSY_OUT   = grav_busy;

   // ************************************************************
   // Assertions
   // ************************************************************
   sequence s_ctrl_write;
      REG_WRITE_IN && REG_ADDR_IN == CTRL_ADDR && !ACCESS_BLOCKED_OUT;
   endsequence
   sequence s_mem_fail;
      mem_done && !MEM_CHECK_OK_IN;
   endsequence
   property p_rst_flag_no_set;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      !FRAME_RST_FLAG_OUT |=> !FRAME_RST_FLAG_OUT;
   endproperty
   a_rst_flag_no_set: assert property (p_rst_flag_no_set)
      else $error("power-on-reset flag set by a write");
   property p_rst_flag_clear;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      s_ctrl_write and !REG_WDATA_IN[RST_FLAG_BIT] |=> !FRAME_RST_FLAG_OUT;
   endproperty
   a_rst_flag_clear: assert property (p_rst_flag_clear)
      else $error("power-on-reset flag not cleared by zero write");
   property p_cont_lock;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      s_ctrl_write and REG_WDATA_IN[PDOWN_BIT] |=> !CONT_CHECK_ENABLE_OUT
         && POWER_DOWN_OUT && !ctrl_reg[GRAV_BIT] && !ctrl_reg[MEM_BIT];
   endproperty
   a_cont_lock: assert property (p_cont_lock)
      else $error("check bit accepted with power-down");
   property p_grav_start;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      s_ctrl_write and REG_WDATA_IN[GRAV_BIT] and !check_lock
         and !ctrl_reg[GRAV_BIT] |=> GRAV_CHECK_BUSY_OUT[*8];
   endproperty
   a_grav_start: assert property (p_grav_start)
      else $error("gravity check did not start");
   property p_grav_end;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      grav_done && !REG_WRITE_IN |=> !ctrl_reg[GRAV_BIT]
         && !GRAV_CHECK_BUSY_OUT;
   endproperty
   a_grav_end: assert property (p_grav_end)
      else $error("gravity start bit not cleared at end");
   property p_mem_end;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      mem_done |=> !ctrl_reg[MEM_BIT] && !ACCESS_BLOCKED_OUT;
   endproperty
   a_mem_end: assert property (p_mem_end)
      else $error("memory start bit not cleared at end");
   property p_startup;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      $fell(startup_reg) |-> ACCESS_BLOCKED_OUT[*8];
   endproperty
   a_startup: assert property (p_startup)
      else $error("memory check not run at startup");
   property p_blocked;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      ACCESS_BLOCKED_OUT && REG_READ_IN |=> $stable(REG_RDATA_OUT);
   endproperty
   a_blocked: assert property (p_blocked)
      else $error("read served during memory check");
   property p_mem_fail;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      s_mem_fail |=> checksum_fault_reg ##1 FRAME_DIAG_OUT;
   endproperty
   a_mem_fail: assert property (p_mem_fail)
      else $error("memory check failure not reported");
   property p_low_pad;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      rd_ok && REG_ADDR_IN == AXIS_LOW_BASE && !FRAME_DIAG_OUT
         && !$past(FRAME_DIAG_OUT) |=> REG_RDATA_OUT[1:0] == AXIS_PAD;
   endproperty
   a_low_pad: assert property (p_low_pad)
      else $error("unused low axis bits not zero");

endmodule

// ==== accel_regs_pkg.sv ====
// Constants shared by the accelerometer control and self-test block
//
// Overview of operation
// - Reset by power-on or undervoltage sets the power-on-reset flag.
// - Writing one to the power-on-reset flag does nothing; zero clears it.
// - Every output frame carries the power-on-reset flag in bit 3.
// - Control bit 5 set to one holds the sensing path powered down.
// - Control bit 3 enables continuous check; result in status and diag bit.
// - Bits 3 and 1 refuse one while power-down or memory check is set.
// - Bit 2 starts memory check and clears itself when finished.
// - Bit 2 refuses one while power-down is set or being set.
// - Memory check runs by itself at startup.
// - Memory check failure sets checksum fault and the diag bit.
// - Register access is blocked for 85 us during the memory check.
// - Bit 1 starts the gravity check and clears itself when finished.
// - Continuous and gravity checks may run at the same time.
// - Gravity check failure sets its status flag and the diag bit.
// - Each axis is a 14-bit two's-complement value over two bytes.
// - Zero acceleration reads 0000h.
// - Output scaling is 650 LSB per g.
// - Reading the high byte latches the low byte; host reads high first.
// - The two lowest bits of each axis word are unused, read zero; the fault words 7FFFh and FFFFh read ones there.
// - During reset all acceleration outputs read zero.
package accel_regs_pkg;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [7:0] CTRL_ADDR       = 8'h01;
   localparam logic [7:0] STATUS_ADDR     = 8'h02;
   localparam logic [7:0] AXIS_LOW_BASE   = 8'h04;
   localparam logic [7:0] AXIS_HIGH_BASE  = 8'h05;
   localparam logic [7:0] AXIS_STRIDE     = 8'h02;
   localparam logic [7:0] INT_STATUS_ADDR = 8'h16;
   localparam logic [7:0] IDENT_ADDR      = 8'h27;

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int unsigned RST_FLAG_BIT  = 6;
   localparam int unsigned PDOWN_BIT     = 5;
   localparam int unsigned CONT_BIT      = 3;
   localparam int unsigned MEM_BIT       = 2;
   localparam int unsigned GRAV_BIT      = 1;
   localparam int unsigned CSUM_BIT      = 1;
   localparam int unsigned INT_GRAV_BIT  = 5;
   localparam int unsigned INT_CONT_BIT  = 4;
   localparam logic [7:0]  CTRL_RESET    = 8'h40;
   localparam logic [7:0]  CTRL_RSVD     = 8'h91;
   localparam logic [7:0]  BYTE_ZERO     = 8'h00;
   // Arbitrary identification value
   localparam logic [7:0]  IDENT_DEFAULT = 8'h3C;

   // ************************************************************
   // Acceleration word format
   // ************************************************************
   localparam int unsigned AXIS_COUNT     = 3;
   localparam int unsigned AXIS_BITS      = 14;
   localparam logic [1:0]  AXIS_PAD       = 2'h0;
   localparam logic [15:0] WORD_ZERO      = 16'h0000;
   localparam logic [15:0] WORD_MEM_FAIL  = 16'h7FFF;
   localparam logic [15:0] WORD_PATH_FAIL = 16'hFFFF;
   // Scaling is done by the sensing path ahead of this block
   localparam int unsigned SENSITIVITY_LSB_PER_G = 650;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_PERIOD_NS     = 20;
   localparam int unsigned MEM_CHECK_TIME_NS = 85000;
   localparam int unsigned MEM_CHECK_CYCLES  =
      (MEM_CHECK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned GRAV_CHECK_CYCLES = 256;
   localparam int unsigned TIMER_BITS        = 16;

endpackage

// ==== check_timer.sv ====
// Fixed-length busy window for one self-test run
`timescale 1ns/100ps
module check_timer
#(
   parameter int unsigned LENGTH = accel_regs_pkg::MEM_CHECK_CYCLES
)
(
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic resetn_in,
   // Control
   input  wire logic start_in,
   // Status
   output logic      busy_out,
   output logic      done_out
);
   import accel_regs_pkg::*;

   localparam logic [TIMER_BITS-1:0] LAST = TIMER_BITS'(LENGTH - 1);

   logic [TIMER_BITS-1:0] count_reg;
   logic                  busy_reg;

   // ************************************************************
   // Window counter
   // ************************************************************
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         busy_reg  <= 1'b0;
         count_reg <= '0;
      end
      else if (start_in && !busy_reg)
      begin
         busy_reg  <= 1'b1;
         count_reg <= '0;
      end
      else if (busy_reg)
      begin
         if (count_reg == LAST)
            busy_reg <= 1'b0;
         count_reg <= count_reg + 1'b1;
      end
   end

   assign busy_out = busy_reg;
   assign done_out = busy_reg && (count_reg == LAST);

endmodule

// ==== host_model.sv ====
// Host model that operates the decoded register access port
`timescale 1ns/100ps
module host_model
   import accel_regs_pkg::*;
(
   // Clock
   input  wire logic clk_in,
   // Access port
   input  wire logic blocked_in,
   output logic [7:0] addr_out,
   output logic       write_out,
   output logic [7:0] wdata_out,
   output logic       read_out
);
   initial
   begin
      addr_out  = 8'h00;
      write_out = 1'b0;
      wdata_out = 8'h00;
      read_out  = 1'b0;
   end

   // ************************************************************
   // Access tasks
   // ************************************************************
   // No access while the memory check holds the port
   task automatic idle_wait();
      int n;
      n = 0;
      while (blocked_in !== 1'b0 && n < 10000)
      begin
         @(posedge clk_in);
         n++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      idle_wait();
      addr_out  <= a;
      wdata_out <= d & ~CTRL_RSVD;
      write_out <= 1'b1;
      @(posedge clk_in);
      write_out <= 1'b0;
      // Released lines show a changed value, not the old one
      addr_out  <= ~a;
      wdata_out <= ~d;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk_in);
      idle_wait();
      addr_out <= a;
      read_out <= 1'b1;
      @(posedge clk_in);
      read_out <= 1'b0;
      addr_out <= ~a;
   endtask
endmodule

// ==== tb.sv ====
// Self-checking testbench of the control and self-test register block
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("Error %s expected %h seen %h", nm, exp, got); \
      end \
   end
module tb;
   import accel_regs_pkg::*;
   localparam int unsigned MEMC  = 20;
   localparam int unsigned GRAVC = 16;
   logic        clk;
   logic        resetn;
   logic [7:0]  addr;
   logic        wr;
   logic [7:0]  wdata;
   logic        rd;
   logic [7:0]  rdata;
   logic        rst_flag;
   logic        diag;
   logic        blocked;
   logic [13:0] smp [3];
   logic        pdown;
   logic        mem_ok;
   logic        cont_fail;
   logic        grav_fail;
   logic        cont_en;
   logic        grav_busy;
   logic        taken_d;
   logic [7:0]  exp_v;
   logic [7:0]  exp_q [$];
   integer      seed;
   int          mismatches;
   int          total_checks;

   always #10 clk = ~clk;

   accel_control_selftest_regs #(.MEM_CYCLES(MEMC), .GRAV_CYCLES(GRAVC))
   i_accel_control_selftest_regs
   (
      .CLK_IN(clk), .RESETN_IN(resetn), .REG_ADDR_IN(addr),
      .REG_WRITE_IN(wr), .REG_WDATA_IN(wdata), .REG_READ_IN(rd),
      .REG_RDATA_OUT(rdata), .FRAME_RST_FLAG_OUT(rst_flag),
      .FRAME_DIAG_OUT(diag), .ACCESS_BLOCKED_OUT(blocked),
      .AXIS_X_IN(smp[0]), .AXIS_Y_IN(smp[1]), .AXIS_Z_IN(smp[2]),
      .POWER_DOWN_OUT(pdown), .MEM_CHECK_OK_IN(mem_ok),
      .CONT_CHECK_FAIL_IN(cont_fail), .GRAV_CHECK_FAIL_IN(grav_fail),
      .CONT_CHECK_ENABLE_OUT(cont_en), .GRAV_CHECK_BUSY_OUT(grav_busy)
   );

   host_model i_host_model
   (
      .clk_in(clk), .blocked_in(blocked), .addr_out(addr),
      .write_out(wr), .wdata_out(wdata), .read_out(rd)
   );

   // ************************************************************
   // Read monitor: data is due one cycle after a served read
   // ************************************************************
   always @(posedge clk)
   begin
      if (taken_d === 1'b1)
      begin
         exp_v = exp_q.pop_front();
         `CHK("read data", exp_v, rdata)
      end
      taken_d <= rd & ~blocked & resetn;
   end

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_host_model.rd(a);
   endtask

   // Counts busy cycles until the port is free again
   task automatic wait_free(output int n);
      int k;
      n = 0;
      for (k = 0; k < 2000; k++)
      begin
         @(posedge clk);
         if (blocked === 1'b1)
            n++;
         else if (n > 0)
            break;
      end
   endtask

   task automatic do_reset();
      int n;
      @(posedge clk);
      resetn <= 1'b0;
      repeat (12) @(posedge clk);
      `CHK("reset rdata", BYTE_ZERO, rdata)
      `CHK("reset flag", 1'b1, rst_flag)
      resetn <= 1'b1;
      wait_free(n);
      `CHK("startup check", MEMC, n)
      rd_chk(CTRL_ADDR, CTRL_RESET);
   endtask

   task automatic results();
      $display("Checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Run is a few hundred cycles; this is over a hundred times that
   initial
   begin
      #800000;
      mismatches++;
      results();
   end

   initial
   begin
      logic [7:0]  w_tab [4];
      logic [7:0]  e_tab [4];
      logic [15:0] w;
      int          i;
      int          j;
      int          k;
      int          n;
      w_tab = '{8'h20, 8'h2E, 8'h00, 8'h2C};
      e_tab = '{8'h20, 8'h20, 8'h00, 8'h20};
      seed = 32'h38aefbbd;
      clk = 1'b0;
      resetn = 1'b0;
      mem_ok = 1'b1;
      cont_fail = 1'b0;
      grav_fail = 1'b0;
      smp = '{14'h0000, 14'h0000, 14'h0000};
      mismatches = 0;
      total_checks = 0;
      do_reset();
      `CHK("frame flag", 1'b1, rst_flag)
      i_host_model.wr(CTRL_ADDR, 8'h40);
      rd_chk(CTRL_ADDR, 8'h40);
      i_host_model.wr(CTRL_ADDR, 8'h00);
      rd_chk(CTRL_ADDR, 8'h00);
      `CHK("frame flag", 1'b0, rst_flag)
      // ************************************************************
      // Interlocks against power-down, already set and being set
      // ************************************************************
      for (i = 0; i < 4; i++)
      begin
         i_host_model.wr(CTRL_ADDR, w_tab[i]);
         rd_chk(CTRL_ADDR, e_tab[i]);
         `CHK("power down", e_tab[i][5], pdown)
         `CHK("cont enable", 1'b0, cont_en)
      end
      i_host_model.wr(CTRL_ADDR, 8'h00);
      // ************************************************************
      // Memory check, first failing then passing
      // ************************************************************
      mem_ok <= 1'b0;
      i_host_model.wr(CTRL_ADDR, 8'h0E);
      wait_free(n);
      `CHK("mem busy", MEMC, n)
      rd_chk(CTRL_ADDR, 8'h00);
      rd_chk(STATUS_ADDR, 8'h02);
      `CHK("diag", 1'b1, diag)
      rd_chk(AXIS_LOW_BASE + 8'h01, WORD_MEM_FAIL[15:8]);
      rd_chk(AXIS_LOW_BASE, WORD_MEM_FAIL[7:0]);
      mem_ok <= 1'b1;
      i_host_model.wr(CTRL_ADDR, 8'h04);
      wait_free(n);
      rd_chk(STATUS_ADDR, 8'h00);
      `CHK("diag", 1'b0, diag)
      // ************************************************************
      // Gravity and continuous checks side by side
      // ************************************************************
      grav_fail <= 1'b1;
      i_host_model.wr(CTRL_ADDR, 8'h0A);
      @(negedge clk);
      `CHK("cont enable", 1'b1, cont_en)
      `CHK("grav busy", 1'b1, grav_busy)
      for (k = 0; k < 100 && grav_busy !== 1'b0; k++)
         @(posedge clk);
      grav_fail <= 1'b0;
      rd_chk(CTRL_ADDR, 8'h08);
      `CHK("diag", 1'b1, diag)
      rd_chk(INT_STATUS_ADDR, 8'h20);
      rd_chk(INT_STATUS_ADDR, 8'h00);
      @(posedge clk);
      cont_fail <= 1'b1;
      @(posedge clk);
      cont_fail <= 1'b0;
      rd_chk(INT_STATUS_ADDR, 8'h10);
      rd_chk(INT_STATUS_ADDR, 8'h00);
      i_host_model.wr(CTRL_ADDR, 8'h00);
      // ************************************************************
      // Axis words, high byte latching the low byte
      // ************************************************************
      for (i = 0; i < 6; i++)
      begin
         for (j = 0; j < 3; j++)
            smp[j] <= (i == 0) ? 14'h0000 : 14'($random(seed));
         repeat (3) @(posedge clk);
         for (j = 0; j < 3; j++)
         begin
            w = {smp[j], AXIS_PAD};
            rd_chk(AXIS_LOW_BASE + 8'(2 * j + 1), w[15:8]);
            smp[j] <= ~smp[j];
            rd_chk(AXIS_LOW_BASE + 8'(2 * j), w[7:0]);
         end
      end
      rd_chk(8'h30, BYTE_ZERO);
      rd_chk(IDENT_ADDR, IDENT_DEFAULT);
      // Second reset in mid-run raises the flag again
      do_reset();
      `CHK("frame flag", 1'b1, rst_flag)
      repeat (4) @(posedge clk);
      results();
   end
endmodule
